// ===== verilog/modem_ctl_pkg.sv
/*
  Shared constants for the modem control, modem status and baud generator block:
  register byte offsets, field positions, reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses, one word per register.
*/
package modem_ctl_pkg;

  // ----------------------------------------------------------------
  // Clock and baud generator figures
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned CLK_RATE_HZ     = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned REF_MAX_HZ      = 16000000;
  localparam int unsigned SAMPLE_PER_BAUD = 16;
  localparam int unsigned DIV_W           = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_MODEM_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODEM_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIV_LOW       = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DIV_HIGH      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK      = 8'h14;

  // ----------------------------------------------------------------
  // Modem control register fields
  // ----------------------------------------------------------------
  localparam int unsigned MC_DTR      = 0;
  localparam int unsigned MC_RTS      = 1;
  localparam int unsigned MC_OUT_ONE  = 2;
  localparam int unsigned MC_OUT_TWO  = 3;
  localparam int unsigned MC_LOOPBACK = 4;
  localparam int unsigned MC_AUTOFLOW = 5;
  localparam int unsigned MC_W        = 6;

  // ----------------------------------------------------------------
  // Modem status register fields (change bits low, line state high)
  // ----------------------------------------------------------------
  localparam int unsigned MS_CTS      = 0;
  localparam int unsigned MS_DSR      = 1;
  localparam int unsigned MS_RI       = 2;
  localparam int unsigned MS_DCD      = 3;
  localparam int unsigned MS_LINE_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MC_W-1:0] RST_MODEM_CONTROL = 6'h00;
  localparam logic [7:0]      RST_DIV_BYTE      = 8'h00;
  localparam logic [3:0]      RST_LINE          = 4'h0;
  localparam logic [3:0]      RST_PIN_LEVEL     = 4'hf;
  localparam logic [3:0]      RST_IRQ_MASK      = 4'h0;
  localparam logic [DIV_W-1:0] RST_BAUD_COUNT   = 16'h0000;

  // ----------------------------------------------------------------
  // AXI4-Lite response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== verilog/baud_divider.sv
/*
  Baud divider: counts clock cycles down from the programmed divisor and emits
  one 16x sample tick per divisor cycles.
  Assumes the reload pulse arrives in the same cycle as the new divisor value.
*/
`timescale 1ns/100ps
module baud_divider
  import modem_ctl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clkEn,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             reload,
  output logic                  baudTick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } baud_state_t;

  baud_state_t s_r;
  baud_state_t s_nxt;

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  // Zero divisor parks the counter; software must program it first
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (reload) begin
      s_nxt.cnt = divisor;
    end else if (divisor == RST_BAUD_COUNT) begin
      s_nxt.cnt = RST_BAUD_COUNT;
    end else if (s_r.cnt <= 16'h0001) begin
      s_nxt.tick = 1'b1;
      s_nxt.cnt  = divisor;
    end else begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  assign baudTick = s_r.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  baud_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clkEn && !reload && divisor != 16'h0000 && s_r.cnt <= 16'h0001) |=> baudTick)
    else $error("baud tick missing at terminal count");

  baud_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clkEn && reload) |=> (s_r.cnt == $past(divisor) && !baudTick))
    else $error("baud counter not reloaded on divisor write");

endmodule // baud_divider

// ===== verilog/modem_control_status_baud.sv
/*
  Modem control, modem status, local loopback and baud generator of a serial
  communications element, with an AXI4-Lite register slave and an interrupt output.
  Assumes the transmitter and receiver sit outside and meet this block at the
  shift register taps; modem pins arrive asynchronously and are synchronised here.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
// What this block does
// - Control bits 0..3 drive DTR, RTS, output one, output two, low when set.
// - Loopback holds serial output high and feeds transmit shift out to receiver.
// - Loopback ignores modem inputs, routes control bits inside, forces pins high.
// - Loopback modem interrupts come from control bits; enable gating still applies.
// - Bit 5 enables autoflow: with bit 1 both directions, else CTS only.
// - Change bits set on input change; reading status clears all four.
// - CTS change flag interrupts only without autoflow; with autoflow it stays clear.
// - DSR and DCD change flags raise the modem interrupt when enabled.
// - Ring flag sets when the ring input rises low to high.
// - Status bits 4..7 read complements of CTS, DSR, RI, DCD pins.
// - In loopback status bits 4..7 equal control bits 1, 0, 2, 3.
// - Baud generator divides reference by divisor 1..65535 to a 16x tick.
// - Divisor held in two byte latches; writing either reloads the counter.
`timescale 1ns/100ps
module modem_control_status_baud
  import modem_ctl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clkEn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Modem pins, active low
  input  wire logic              ctsN,
  input  wire logic              dsrN,
  input  wire logic              riN,
  input  wire logic              dcdN,
  output logic                   dtrN,
  output logic                   rtsN,
  output logic                   userOutputOneN,
  output logic                   userOutputTwoN,
  // Serial pins and shift register taps
  input  wire logic              serialIn,
  output logic                   serialOut,
  input  wire logic              transmitShiftOut,
  output logic                   receiveShiftIn,
  // Link to interrupt and flow logic outside
  input  wire logic              modemIntEnable,
  output logic                   modemStatusIrq,
  output logic                   autoRtsEnable,
  output logic                   autoCtsEnable,
  output logic                   baudTick,
  output logic                   irq
);

  typedef struct packed {
    logic [MC_W-1:0]   ctrl;
    logic [7:0]        divLow;
    logic [7:0]        divHigh;
    logic              reload;
    logic [3:0]        delta;
    logic [3:0]        lineNow;
    logic [3:0]        pinSync1;
    logic [3:0]        pinSync2;
    logic              rxPinSync1;
    logic              rxPinSync2;
    logic [3:0]        pinOut;
    logic [3:0]        irqStat;
    logic [3:0]        irqMask;
    logic              awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic              wHeld;
    logic [7:0]        wByte;
    logic              wLane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rByte;
    logic [1:0]        rresp;
  } modem_state_t;

  modem_state_t s_r;
  modem_state_t s_nxt;

  // Bus handshakes, gated so that a frozen block never takes a beat
  logic awTake;
  logic wTake;
  logic arTake;
  logic doWrite;
  logic [3:0] lineNxt;
  logic [3:0] lineChange;
  logic [3:0] deltaSet;
  logic       loopNxt;

  assign awready = clkEn && !s_r.awHeld;
  assign wready  = clkEn && !s_r.wHeld;
  assign arready = clkEn && !s_r.rvalid;
  assign awTake  = awvalid && awready;
  assign wTake   = wvalid && wready;
  assign arTake  = arvalid && arready;
  assign doWrite = s_r.awHeld && s_r.wHeld && !s_r.bvalid;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [8:0] read_reg(input logic [ADDR_W-1:0] a, input modem_state_t s);
    logic [8:0] r;
    r = {1'b0, 8'h00};
    unique case (a)
      OFF_MODEM_CONTROL: r = {1'b1, 2'b00, s.ctrl};
      OFF_MODEM_STATUS:  r = {1'b1, s.lineNow, s.delta};
      OFF_DIV_LOW:       r = {1'b1, s.divLow};
      OFF_DIV_HIGH:      r = {1'b1, s.divHigh};
      OFF_IRQ_STATUS:    r = {1'b1, 4'h0, s.irqStat};
      OFF_IRQ_MASK:      r = {1'b1, 4'h0, s.irqMask};
      default:           r = {1'b0, 8'h00};
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] rd;
    logic       wrHit;
    rd    = 9'h000;
    wrHit = 1'b0;
    s_nxt = s_r;

    // Two-stage synchronisers on every pin input
    s_nxt.pinSync1 = {dcdN, riN, dsrN, ctsN};
    s_nxt.pinSync2 = s_r.pinSync1;
    s_nxt.rxPinSync1 = serialIn;
    s_nxt.rxPinSync2 = s_r.rxPinSync1;

    // Write address and data are caught independently, in either order
    if (awTake) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wTake) begin
      s_nxt.wHeld  = 1'b1;
      s_nxt.wByte  = wdata[7:0];
      s_nxt.wLane0 = wstrb[0];
    end
    if (bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Register write once both halves are held; upper byte lanes carry nothing
    s_nxt.reload = 1'b0;
    if (doWrite) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      unique case (s_r.awAddr)
        OFF_MODEM_CONTROL: begin
          wrHit = 1'b1;
          if (s_r.wLane0) begin
            s_nxt.ctrl = s_r.wByte[MC_W-1:0];
          end
        end
        OFF_MODEM_STATUS: begin
          wrHit = 1'b1;
        end
        OFF_DIV_LOW: begin
          wrHit = 1'b1;
          if (s_r.wLane0) begin
            s_nxt.divLow = s_r.wByte;
            s_nxt.reload = 1'b1;
          end
        end
        OFF_DIV_HIGH: begin
          wrHit = 1'b1;
          if (s_r.wLane0) begin
            s_nxt.divHigh = s_r.wByte;
            s_nxt.reload  = 1'b1;
          end
        end
        OFF_IRQ_STATUS: begin
          wrHit = 1'b1;
          if (s_r.wLane0) begin
            s_nxt.irqStat = s_r.irqStat & ~s_r.wByte[3:0];
          end
        end
        OFF_IRQ_MASK: begin
          wrHit = 1'b1;
          if (s_r.wLane0) begin
            s_nxt.irqMask = s_r.wByte[3:0];
          end
        end
        default: wrHit = 1'b0;
      endcase
      if (!wrHit) begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end

    // Read: data captured from the current state, answer the next cycle
    if (rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arTake) begin
      rd           = read_reg(araddr, s_r);
      s_nxt.rvalid = 1'b1;
      s_nxt.rByte  = rd[7:0];
      s_nxt.rresp  = rd[8] ? RESP_OKAY : RESP_SLVERR;
      if (araddr == OFF_MODEM_STATUS) begin
        s_nxt.delta = 4'h0;
      end
    end

    // Line state: control bits stand in for the pins during loopback
    loopNxt = s_nxt.ctrl[MC_LOOPBACK];
    if (loopNxt) begin
      s_nxt.lineNow = {s_nxt.ctrl[MC_OUT_TWO], s_nxt.ctrl[MC_OUT_ONE],
                       s_nxt.ctrl[MC_DTR], s_nxt.ctrl[MC_RTS]};
    end else begin
      s_nxt.lineNow = ~s_r.pinSync2;
    end
    // Change detection against the value last registered, kept in here to avoid a loop
    lineNxt    = s_nxt.lineNow;
    lineChange = lineNxt ^ s_r.lineNow;
    deltaSet   = {lineChange[MS_DCD],
                  s_r.lineNow[MS_RI] && !lineNxt[MS_RI],
                  lineChange[MS_DSR],
                  lineChange[MS_CTS] && !s_nxt.ctrl[MC_AUTOFLOW]};

    // Event set wins over the read clear in the same cycle
    s_nxt.delta = s_nxt.delta | deltaSet;
    if (s_nxt.ctrl[MC_AUTOFLOW]) begin
      s_nxt.delta[MS_CTS] = 1'b0;
    end
    s_nxt.irqStat = s_nxt.irqStat | deltaSet;

    // Pins: low while the bit is set, forced high in loopback
    if (loopNxt) begin
      s_nxt.pinOut = 4'hf;
    end else begin
      s_nxt.pinOut = ~s_nxt.ctrl[MC_OUT_TWO:MC_DTR];
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r          <= '0;
      s_r.ctrl     <= RST_MODEM_CONTROL;
      s_r.divLow   <= RST_DIV_BYTE;
      s_r.divHigh  <= RST_DIV_BYTE;
      s_r.lineNow  <= RST_LINE;
      s_r.pinSync1 <= RST_PIN_LEVEL;
      s_r.pinSync2 <= RST_PIN_LEVEL;
      s_r.rxPinSync1 <= 1'b1;
      s_r.rxPinSync2 <= 1'b1;
      s_r.pinOut   <= RST_PIN_LEVEL;
      s_r.irqMask  <= RST_IRQ_MASK;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bvalid = s_r.bvalid;
  assign bresp  = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rresp  = s_r.rresp;
  assign rdata  = {24'h000000, s_r.rByte};

  assign {userOutputTwoN, userOutputOneN, rtsN, dtrN} = s_r.pinOut;

  // Loopback mux; the loopback and transmit paths stay combinational, serial input comes through its two-stage synchroniser
  assign serialOut      = s_r.ctrl[MC_LOOPBACK] ? 1'b1 : transmitShiftOut;
  assign receiveShiftIn = s_r.ctrl[MC_LOOPBACK] ? transmitShiftOut : s_r.rxPinSync2;

  assign autoCtsEnable = s_r.ctrl[MC_AUTOFLOW];
  assign autoRtsEnable = s_r.ctrl[MC_AUTOFLOW] && s_r.ctrl[MC_RTS];

  // CTS change is masked here too, so autoflow can never leak an interrupt
  assign modemStatusIrq = modemIntEnable && (|s_r.delta[MS_DCD:MS_DSR] ||
                          (s_r.delta[MS_CTS] && !s_r.ctrl[MC_AUTOFLOW]));
  assign irq = |(s_r.irqStat & s_r.irqMask);

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Reference clock is the block clock; REF_MAX_HZ is declared but nothing here checks against it
  baud_divider baud_gen (
    .clk      (clk),
    .reset_n  (reset_n),
    .clkEn    (clkEn),
    .divisor  ({s_r.divHigh, s_r.divLow}),
    .reload   (s_r.reload),
    .baudTick (baudTick)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pin_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    !s_r.ctrl[MC_LOOPBACK] |-> ({userOutputTwoN, userOutputOneN, rtsN, dtrN} == ~s_r.ctrl[3:0]))
    else $error("modem output pin does not follow control bit");

  loop_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.ctrl[MC_LOOPBACK] |-> (dtrN && rtsN && userOutputOneN && userOutputTwoN))
    else $error("modem output pin not high in loopback");

  loop_serial_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.ctrl[MC_LOOPBACK] |-> (serialOut && receiveShiftIn == transmitShiftOut))
    else $error("serial loopback path wrong");

  auto_flow_a: assert property (@(posedge clk) disable iff (!reset_n)
    autoCtsEnable == s_r.ctrl[MC_AUTOFLOW] && autoRtsEnable == (s_r.ctrl[5] && s_r.ctrl[1]))
    else $error("autoflow configuration wrong");

  read_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clkEn && arTake && araddr == OFF_MODEM_STATUS && deltaSet == 4'h0) |=> s_r.delta == 4'h0)
    else $error("status read did not clear change bits");

  cts_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clkEn && s_nxt.ctrl[MC_AUTOFLOW]) |=> !s_r.delta[MS_CTS])
    else $error("cts change set while autoflow on");

  modem_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
    (modemIntEnable && $rose(s_r.delta[MS_DSR] || s_r.delta[MS_DCD])) |-> modemStatusIrq)
    else $error("dsr or dcd change raised no interrupt");

  ring_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clkEn && s_r.lineNow[MS_RI] && !lineNxt[MS_RI]) |=> s_r.delta[MS_RI])
    else $error("ring trailing edge not flagged");

  loop_status_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.ctrl[MC_LOOPBACK] |-> s_r.lineNow == {s_r.ctrl[3], s_r.ctrl[2], s_r.ctrl[0], s_r.ctrl[1]})
    else $error("loopback line state does not mirror control bits");

  pin_status_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clkEn && !s_nxt.ctrl[MC_LOOPBACK]) |=> s_r.lineNow == ~$past(s_r.pinSync2))
    else $error("line state is not the pin complement");

  irq_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clkEn && deltaSet != 4'h0) |=> ((s_r.irqStat & $past(deltaSet)) == $past(deltaSet)))
    else $error("change event did not set interrupt status");

endmodule // modem_control_status_baud

// ===== sim/modem_model.sv
/*
  Modem stand-in: drives the four active-low status lines as told.
  Assumes the bench gives one level per line, active high, in CTS, DSR, RI, DCD order.
*/
`timescale 1ns/100ps
module modem_model (
  input  wire logic [3:0] lineOn,
  output logic            ctsN,
  output logic            dsrN,
  output logic            riN,
  output logic            dcdN
);
  // Pins idle high; no hold-over of a stale level
  assign {dcdN, riN, dsrN, ctsN} = ~lineOn;
endmodule // modem_model

// ===== sim/tb.sv
/*
  Self-checking bench: register bus master, modem stand-in, one task per scenario.
  Assumes 20 MHz clock, asynchronous active-low reset, clkEn held high.
*/
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb;
  import modem_ctl_pkg::*;
  logic clk = 0, reset_n = 0, clkEn = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, serialIn = 1, transmitShiftOut = 1, modemIntEnable = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hf, lineOn = 4'h0;
  logic [1:0] bresp, rresp, rrespGot, brespGot;
  logic awready, wready, bvalid, arready, rvalid, ctsN, dsrN, riN, dcdN, dtrN, rtsN;
  logic userOutputOneN, userOutputTwoN, serialOut, receiveShiftIn, modemStatusIrq;
  logic autoRtsEnable, autoCtsEnable, baudTick, irq;
  int failures = 0, samples_checked = 0, k;

  modem_control_status_baud u_dut (.clk, .reset_n, .clkEn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ctsN, .dsrN, .riN, .dcdN, .dtrN, .rtsN,
    .userOutputOneN, .userOutputTwoN, .serialIn, .serialOut, .transmitShiftOut,
    .receiveShiftIn, .modemIntEnable, .modemStatusIrq, .autoRtsEnable, .autoCtsEnable,
    .baudTick, .irq);
  modem_model u_modem (.lineOn, .ctsN, .dsrN, .riN, .dcdN);

  // Free-running clock, 50 ns period
  always #25 clk = ~clk;

  // --------------------------------------------------------------
  // Bus and check helpers
  // --------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (awready) begin aw = 0; awvalid <= 1'b0; end
      if (wready) begin w = 0; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (!bvalid);
    brespGot = bresp;
    bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rrespGot = rresp;
    rready <= 1'b0;
  endtask

  // Level changes need the synchroniser plus the flag edge to land
  task lines(input logic [3:0] v);
    @(posedge clk) lineOn <= v;
    repeat (5) @(posedge clk);
  endtask

  task ticks(input int n);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if (baudTick) k++;
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_reset;
    int i;
    rdr(OFF_MODEM_CONTROL); `CHK(rd, 0);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 0);
    `CHK({userOutputTwoN, userOutputOneN, rtsN, dtrN}, 4'hf);
    ticks(20); `CHK(k, 0);
    rdr(8'h18); `CHK(rrespGot, RESP_SLVERR);
    `CHK(rd, 0);
    wr(8'h18, 1); `CHK(brespGot, RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      wr(OFF_MODEM_CONTROL, 1 << i);
      `CHK({userOutputTwoN, userOutputOneN, rtsN, dtrN}, 4'(~(4'h1 << i)));
    end
    wr(OFF_MODEM_CONTROL, 0); `CHK(brespGot, RESP_OKAY);
    $display("reset and outputs done");
  endtask

  task t_status;
    wr(OFF_IRQ_MASK, 0);
    lines(4'b1011);
    `CHK(modemStatusIrq, 0);
    `CHK(irq, 0);
    @(posedge clk) modemIntEnable <= 1'b1;
    @(posedge clk);
    `CHK(modemStatusIrq, 1);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'hbb);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'hb0);
    `CHK(modemStatusIrq, 0);
    lines(4'b1111);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'hf0);
    lines(4'b1011);
    `CHK(modemStatusIrq, 1);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'hb4);
    rdr(OFF_IRQ_STATUS); `CHK(rd, 4'hf);
    wr(OFF_IRQ_MASK, 4); `CHK(irq, 1);
    wr(OFF_IRQ_STATUS, 4); `CHK(irq, 0);
    rdr(OFF_IRQ_STATUS); `CHK(rd, 4'hb);
    $display("modem status done");
  endtask

  task t_loop;
    wr(OFF_MODEM_CONTROL, 8'h1f);
    `CHK({userOutputTwoN, userOutputOneN, rtsN, dtrN}, 4'hf);
    `CHK(serialOut, 1);
    @(posedge clk) serialIn <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(receiveShiftIn, 1);
    lines(4'h0);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'hf0);
    wr(OFF_MODEM_CONTROL, 8'h11);
    `CHK(modemStatusIrq, 1);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'h2d);
    wr(OFF_MODEM_CONTROL, 0);
    @(posedge clk) begin serialIn <= 1'b1; transmitShiftOut <= 1'b0; end
    repeat (4) @(posedge clk);
    `CHK({serialOut, receiveShiftIn}, 2'b01);
    @(posedge clk) serialIn <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(receiveShiftIn, 0);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'h02);
    $display("loopback done");
  endtask

  task t_flow;
    wr(OFF_MODEM_CONTROL, 8'h20);
    `CHK({autoRtsEnable, autoCtsEnable}, 2'b01);
    lines(4'b0001);
    `CHK(modemStatusIrq, 0);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'h10);
    wr(OFF_MODEM_CONTROL, 8'h22);
    `CHK({autoRtsEnable, autoCtsEnable, rtsN}, 3'b110);
    wr(OFF_MODEM_CONTROL, 8'h02);
    `CHK({autoRtsEnable, autoCtsEnable}, 2'b00);
    lines(4'b0000);
    `CHK(modemStatusIrq, 1);
    rdr(OFF_MODEM_STATUS); `CHK(rd, 8'h01);
    $display("autoflow done");
  endtask

  task t_baud;
    wr(OFF_DIV_HIGH, 0);
    wr(OFF_DIV_LOW, 3);
    // Window opens on the reload edge; first tick a full divisor later
    ticks(30); `CHK(k, 9);
    wr(OFF_DIV_LOW, 1);
    ticks(30); `CHK(k, 29);
    wr(OFF_DIV_HIGH, 1);
    wr(OFF_DIV_LOW, 0);
    ticks(513); `CHK(k, 2);
    wr(OFF_DIV_HIGH, 0);
    wr(OFF_DIV_LOW, 12);
    ticks(121); `CHK(k, 10);
    $display("baud generator done");
  endtask

  // --------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // --------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run needs about 1000 cycles; twenty times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_status();
    t_loop();
    t_flow();
    t_baud();
    finish_test();
  end
endmodule // tb
